// *** hdl/bmc_addr_decode.sv ***
`timescale 1ns/1ps
`default_nettype none

module bmc_addr_decode
   import bmc_pkg::*;
(
   bmc_dec_if.decoder dec
);

   function automatic logic inRegion(input logic [31:0] addr, input logic [31:0] base,
                                     input logic [31:0] size);
      inRegion = (addr >= base) && ((addr - base) < size);
   endfunction

   logic ramHit;
   logic progHit;
   logic periphHit;

   assign ramHit = inRegion(dec.addr, RAM_BASE, RAM_SIZE);
   assign progHit = inRegion(dec.addr, PROG_BASE, PROG_SIZE);
   assign periphHit = inRegion(dec.addr, PERIPH_BASE, PERIPH_SIZE);

   assign dec.hitRam = ramHit;
   assign dec.mapped = ramHit | progHit | periphHit;

endmodule

`default_nettype wire

// *** hdl/bmc_bus_matrix_config.sv ***
`timescale 1ns/1ps
`default_nettype none

module bmc_bus_matrix_config
   import bmc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] wbAdr,
   input wire logic [31:0] wbDatI,
   output logic [31:0] wbDatO,
   input wire logic [3:0] wbSel,
   input wire logic wbWe,
   input wire logic wbStb,
   input wire logic wbCyc,
   output logic wbAck,
   input wire logic [4:0] initReq,
   input wire logic [4:0][31:0] initAddr,
   input wire logic cpuDebugMode,
   output logic [4:0] initAck,
   output logic [4:0] initBusErr,
   output logic ramWaitState,
   output logic irq
);

   logic [31:0] control_q;
   logic [4:0] errStatus_q;
   logic [4:0] errMask_q;
   logic ack_q;
   logic [31:0] rdData_q;
   bmc_state_t state_q;
   bmc_state_t state_d;
   logic [2:0] owner_q;
   logic [31:0] ownerAddr_q;
   logic [2:0] rrPtr_q;
   logic [2:0] winner;
   logic anyReq;
   logic needWait;
   logic finish;
   logic raiseErr;
   logic [4:0] errEvent;
   logic busRead;
   logic busWrite;
   logic [31:0] wrMask;
   logic [31:0] readMux;
   logic [2:0] arbField;
   logic [4:0] errEnable;
   logic cpuOwner;
   logic take;
   logic [4:0] ownerOneHot;
   logic wrControl;
   logic wrStatus;
   logic wrMaskReg;
   logic [4:0] statusSet;
   logic [4:0] statusClr;
   logic irq_q;

   bmc_dec_if decBus();

   bmc_addr_decode u_decode (
      .dec(decBus)
   );

   assign decBus.addr = ownerAddr_q;

   // Arbitration helpers

   // Out-of-range owner codes give no strobe at all
   function automatic logic [4:0] ownerBit(input logic [2:0] idx);
      logic [4:0] v;
      v = 5'h00;
      if (idx < 3'(INIT_N)) begin
         v[idx] = 1'b1;
      end
      ownerBit = v;
   endfunction

   function automatic logic [2:0] nextIdx(input logic [2:0] idx);
      if (idx >= 3'(INIT_N - 1)) begin
         nextIdx = 3'h0;
      end else begin
         nextIdx = idx + 3'h1;
      end
   endfunction

   // Order tried for the k-th place under each mode
   function automatic logic [2:0] slotIdx(input logic [2:0] mode, input logic [2:0] ptr,
                                          input logic [2:0] k);
      logic [2:0] cand;
      logic [3:0] sum;
      cand = k;
      sum = 4'h0;
      unique case (mode)
         ARB_MODE0: begin
            cand = k;
         end
         ARB_MODE2: begin
            sum = {1'b0, ptr} + {1'b0, k};
            if (sum >= 4'(INIT_N)) begin
               sum = sum - 4'(INIT_N);
            end
            cand = sum[2:0];
         end
         default: begin
            // Reserved codes fall back to mode 1 rather than lock the matrix
            unique case (k)
               3'h0: cand = IDX_DEBUG;
               3'h1: cand = IDX_DMA;
               3'h2: cand = IDX_SHARED;
               3'h3: cand = IDX_DATA;
               default: cand = IDX_FETCH;
            endcase
         end
      endcase
      slotIdx = cand;
   endfunction

   function automatic logic [2:0] pickWinner(input logic [4:0] req, input logic [2:0] mode,
                                             input logic [2:0] ptr);
      logic [2:0] win;
      logic found;
      logic [2:0] cand;
      win = 3'h0;
      found = 1'b0;
      cand = 3'h0;
      for (int k = 0; k < INIT_N; k++) begin
         cand = slotIdx(mode, ptr, 3'(k));
         if (!found && req[cand]) begin
            win = cand;
            found = 1'b1;
         end
      end
      pickWinner = win;
   endfunction

   assign arbField = control_q[CON_ARB_LSB +: 3];
   assign anyReq = |initReq;
   assign winner = pickWinner(initReq, arbField, rrPtr_q);
   // Grant only from idle, one access in flight at a time
   assign take = (state_q == ST_IDLE) && anyReq;

   // Access sequencing

   assign cpuOwner = (owner_q == IDX_FETCH) || (owner_q == IDX_DATA);
   assign needWait = cpuOwner && decBus.hitRam && control_q[CON_WAIT_BIT];
   assign ramWaitState = control_q[CON_WAIT_BIT];

   always_comb begin
      state_d = state_q;
      finish = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            if (anyReq) begin
               state_d = ST_DECODE;
            end
         end
         ST_DECODE: begin
            if (needWait) begin
               state_d = ST_WAIT;
            end else begin
               state_d = ST_IDLE;
               finish = 1'b1;
            end
         end
         ST_WAIT: begin
            state_d = ST_IDLE;
            finish = 1'b1;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         owner_q <= 3'h0;
         ownerAddr_q <= 32'h0000_0000;
      end else if (take) begin
         owner_q <= winner;
         ownerAddr_q <= initAddr[winner];
      end
   end

   // Pointer moves only on a grant so an idle matrix keeps its fairness order
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rrPtr_q <= 3'h0;
      end else if (take) begin
         rrPtr_q <= nextIdx(winner);
      end
   end

   // Unmapped access reporting

   always_comb begin
      errEnable = control_q[CON_ERR_EN_LSB +: INIT_N];
      // CPU reporting is muted while the core is halted for debug
      if (cpuDebugMode) begin
         errEnable[IDX_DATA] = 1'b0;
         errEnable[IDX_FETCH] = 1'b0;
      end
   end

   assign ownerOneHot = ownerBit(owner_q);
   assign raiseErr = finish && !decBus.mapped && |(errEnable & ownerOneHot);

   always_comb begin
      initAck = 5'h00;
      errEvent = 5'h00;
      if (finish) begin
         initAck = ownerOneHot;
      end
      if (raiseErr) begin
         errEvent = ownerOneHot;
      end
   end

   assign initBusErr = errEvent;

   // Wishbone slave

   // Sel bits widen to byte lanes
   function automatic logic [31:0] byteMask(input logic [3:0] sel);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int b = 0; b < 4; b++) begin
         m[8 * b +: 8] = {8{sel[b]}};
      end
      byteMask = m;
   endfunction

   function automatic logic [31:0] mergeWrite(input logic [31:0] old, input logic [31:0] data,
                                              input logic [31:0] laneMask);
      mergeWrite = (old & ~laneMask) | (data & laneMask);
   endfunction

   // Set term applied last so an event outlives its own clear
   function automatic logic [4:0] stickyNext(input logic [4:0] cur, input logic [4:0] clrBits,
                                             input logic [4:0] setBits);
      stickyNext = (cur & ~clrBits) | setBits;
   endfunction

   // Narrow registers read back in the low bits
   function automatic logic [31:0] zeroExt5(input logic [4:0] v);
      zeroExt5 = {27'h0, v};
   endfunction

   // Write lands on the edge where the master sees ack
   assign busWrite = wbCyc && wbStb && wbWe && ack_q;
   assign busRead = wbCyc && wbStb && !wbWe && !ack_q;
   assign wbAck = ack_q;
   assign wrMask = byteMask(wbSel) & CON_WRITE_MASK;
   assign wrControl = busWrite && (wbAdr == OFS_CONTROL);
   assign wrStatus = busWrite && (wbAdr == OFS_ERR_STATUS) && wbSel[0];
   assign wrMaskReg = busWrite && (wbAdr == OFS_ERR_MASK) && wbSel[0];
   assign statusClr = wrStatus ? wbDatI[4:0] : 5'h00;
   assign statusSet = errEvent;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wbCyc && wbStb && !ack_q;
      end
   end

   always_comb begin
      readMux = 32'h0000_0000;
      unique case (wbAdr)
         OFS_CONTROL: readMux = control_q & CON_WRITE_MASK;
         OFS_ERR_STATUS: readMux = zeroExt5(errStatus_q);
         OFS_ERR_MASK: readMux = zeroExt5(errMask_q);
         OFS_ARB_STATE: readMux = {24'h0, 1'b0, rrPtr_q, 1'b0, owner_q} | {state_q, 30'h0};
         default: readMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdData_q <= 32'h0000_0000;
      end else if (busRead) begin
         rdData_q <= readMux;
      end
   end

   assign wbDatO = rdData_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         control_q <= CON_RESET;
      end else if (wrControl) begin
         // Only implemented bits take the write
         control_q <= mergeWrite(control_q, wbDatI, wrMask);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         errMask_q <= MASK_RESET;
      end else if (wrMaskReg) begin
         errMask_q <= wbDatI[4:0];
      end
   end

   // New event wins over a write-one-to-clear in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         errStatus_q <= STAT_RESET;
      end else begin
         errStatus_q <= stickyNext(errStatus_q, statusClr, statusSet);
      end
   end

   // Registered so a bus write cannot glitch the line
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(errStatus_q & errMask_q);
      end
   end

   assign irq = irq_q;

endmodule

`default_nettype wire

// *** hdl/bmc_dec_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface bmc_dec_if;
   logic [31:0] addr;
   logic mapped;
   logic hitRam;

   modport requester(output addr, input mapped, input hitRam);
   modport decoder(input addr, output mapped, output hitRam);
endinterface

`default_nettype wire

// *** hdl/bmc_pkg.sv ***
package bmc_pkg;

   localparam int INIT_N = 5;
   localparam int IDX_W = 3;

   // Initiator index order matches the error enable bit order
   localparam logic [2:0] IDX_FETCH = 3'h0;
   localparam logic [2:0] IDX_DATA = 3'h1;
   localparam logic [2:0] IDX_DMA = 3'h2;
   localparam logic [2:0] IDX_DEBUG = 3'h3;
   localparam logic [2:0] IDX_SHARED = 3'h4;

   localparam int REG_ADDR_W = 8;
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_ERR_STATUS = 8'h04;
   localparam logic [7:0] OFS_ERR_MASK = 8'h08;
   localparam logic [7:0] OFS_ARB_STATE = 8'h0C;

   localparam int CON_ERR_EN_LSB = 16;
   localparam int CON_SHARED_ERR_BIT = 20;
   localparam int CON_DEBUG_ERR_BIT = 19;
   localparam int CON_DMA_ERR_BIT = 18;
   localparam int CON_DATA_ERR_BIT = 17;
   localparam int CON_FETCH_ERR_BIT = 16;
   localparam int CON_WAIT_BIT = 6;
   localparam int CON_ARB_LSB = 0;
   localparam logic [31:0] CON_WRITE_MASK = 32'h001F_0047;
   localparam logic [31:0] CON_RESET = 32'h001F_0041;
   localparam logic [4:0] STAT_RESET = 5'h00;
   localparam logic [4:0] MASK_RESET = 5'h00;

   // Memory map seen by every initiator
   localparam logic [31:0] RAM_BASE = 32'h0000_0000;
   localparam logic [31:0] RAM_SIZE = 32'h0001_0000;
   localparam logic [31:0] PROG_BASE = 32'h1000_0000;
   localparam logic [31:0] PROG_SIZE = 32'h0004_0000;
   localparam logic [31:0] PERIPH_BASE = 32'h2000_0000;
   localparam logic [31:0] PERIPH_SIZE = 32'h0010_0000;

   typedef enum logic [2:0] {
      ARB_MODE0 = 3'b000,
      ARB_MODE1 = 3'b001,
      ARB_MODE2 = 3'b010
   } bmc_arb_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DECODE = 2'b01,
      ST_WAIT = 2'b10
   } bmc_state_t;

endpackage

// *** tb/bmc_bus_matrix_config_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module bmc_bus_matrix_config_chk
   import bmc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] wbAdr,
   input wire logic [31:0] wbDatI,
   input wire logic [31:0] wbDatO,
   input wire logic wbWe,
   input wire logic wbStb,
   input wire logic wbCyc,
   input wire logic wbAck,
   input wire logic cpuDebugMode,
   input wire logic [4:0] initAck,
   input wire logic [4:0] initBusErr,
   input wire logic ramWaitState
);
   logic [31:0] shadowCon_q;
   logic conWr, conRd;
   assign conWr = wbCyc && wbStb && wbWe && wbAck && wbAdr == OFS_CONTROL;
   assign conRd = wbCyc && wbStb && !wbWe && wbAck && wbAdr == OFS_CONTROL;
   // Bench always writes all four bytes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shadowCon_q <= CON_RESET;
      end else if (conWr) begin
         shadowCon_q <= wbDatI & CON_WRITE_MASK;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_shared_err_gate: assert property (initBusErr[4] |-> shadowCon_q[20])
      else $error("shared bus error while disabled");
   a_debug_err_gate: assert property (initBusErr[3] |-> shadowCon_q[19])
      else $error("debug error while disabled");
   a_dma_err_gate: assert property (initBusErr[2] |-> shadowCon_q[18])
      else $error("dma error while disabled");
   a_data_err_mute: assert property (initBusErr[1] |-> shadowCon_q[17] && !cpuDebugMode)
      else $error("cpu data error not gated");
   a_fetch_err_mute: assert property (initBusErr[0] |-> shadowCon_q[16] && !cpuDebugMode)
      else $error("cpu fetch error not gated");
   a_wait_pin_mirror: assert property (ramWaitState == shadowCon_q[6])
      else $error("wait pin differs from control");
   a_ctrl_read_back: assert property (conRd |-> wbDatO == shadowCon_q)
      else $error("control read back wrong");
   a_unimpl_read_zero: assert property (conRd |-> (wbDatO & ~CON_WRITE_MASK) == 32'h0)
      else $error("unimplemented control bits set");
   a_err_with_ack: assert property (|initBusErr |-> (initBusErr & ~initAck) == 5'h00)
      else $error("bus error without ack");
endmodule
bind bmc_bus_matrix_config bmc_bus_matrix_config_chk chk (.clk, .rstn, .wbAdr, .wbDatI,
   .wbDatO, .wbWe, .wbStb, .wbCyc, .wbAck, .cpuDebugMode, .initAck, .initBusErr,
   .ramWaitState);
`default_nettype wire

// *** tb/bmc_init_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bmc_init_model
   import bmc_pkg::*;
(
   input wire logic clk,
   input wire logic [4:0] initAck,
   input wire logic [4:0] initBusErr,
   output var logic [4:0] initReq,
   output var logic [4:0][31:0] initAddr
);
   initial begin
      initReq = 5'h00;
      initAddr = '0;
   end
   task automatic access(input int i, input logic [31:0] a, output int lat, output logic err);
      lat = 0;
      @(posedge clk);
      initReq[i] <= 1'b1;
      initAddr[i] <= a;
      // Answer taken at the edge that samples ack, request dropped there
      do begin
         @(posedge clk);
         lat++;
      end while (initAck[i] !== 1'b1 && lat < 20);
      err = initBusErr[i];
      initReq[i] <= 1'b0;
      // Released address must not look valid
      initAddr[i] <= ~a;
   endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench
   import bmc_pkg::*;
;
   localparam logic [31:0] UNMAPPED = 32'h3000_0000;
   logic clk, rstn, wbWe, wbStb, wbCyc, wbAck, ramWaitState, irq, cpuDebugMode, err;
   logic [7:0] wbAdr;
   logic [31:0] wbDatI, wbDatO, rd;
   logic [3:0] wbSel;
   logic [4:0] initReq, initAck, initBusErr;
   logic [4:0][31:0] initAddr;
   int failures, tests_run, lat;
   int latA, latB;
   logic errA, errB;
   bmc_bus_matrix_config dut (.clk, .rstn, .wbAdr, .wbDatI, .wbDatO, .wbSel, .wbWe, .wbStb,
      .wbCyc, .wbAck, .initReq, .initAddr, .cpuDebugMode, .initAck, .initBusErr,
      .ramWaitState, .irq);
   bmc_init_model model (.clk, .initAck, .initBusErr, .initReq, .initAddr);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task complete_run();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDatI <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      if (wbAck !== 1'b1) begin
         failures++;
         complete_run();
      end
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask
   task acc(input int i, input logic [31:0] a, input int expLat, input logic expErr);
      model.access(i, a, lat, err);
      chk32("init latency", 32'(expLat), 32'(lat));
      chk32("init bus error", {31'h0, expErr}, {31'h0, err});
      if (lat >= 20) begin
         complete_run();
      end
   endtask
   initial begin
      rstn = 1'b0;
      wbCyc = 1'b0;
      wbStb = 1'b0;
      wbWe = 1'b0;
      wbAdr = 8'h00;
      wbDatI = 32'h0;
      wbSel = 4'hF;
      cpuDebugMode = 1'b0;
      failures = 0;
      tests_run = 0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      wbXfer(1'b0, OFS_CONTROL, 32'h0);
      chk32("control reset", CON_RESET, rd);
      for (int i = 0; i < INIT_N; i++) begin
         acc(i, UNMAPPED, 2, 1'b1);
      end
      acc(1, RAM_BASE + 32'h4, 3, 1'b0);
      acc(0, PROG_BASE, 2, 1'b0);
      acc(2, RAM_BASE, 2, 1'b0);
      wbXfer(1'b1, OFS_CONTROL, 32'hFFFF_FFFA);
      wbXfer(1'b0, OFS_CONTROL, 32'h0);
      chk32("control mask", CON_WRITE_MASK & 32'hFFFF_FFFA, rd);
      for (int m = 0; m < 3; m++) begin
         wbXfer(1'b1, OFS_CONTROL, 32'(m));
         wbXfer(1'b0, OFS_CONTROL, 32'h0);
         chk32("arbitration mode", 32'(m), rd);
      end
      chk32("wait pin", 32'h0, {31'h0, ramWaitState});
      for (int i = 0; i < INIT_N; i++) begin
         acc(i, UNMAPPED, 2, 1'b0);
      end
      acc(1, RAM_BASE, 2, 1'b0);
      // Two requests at one edge: mode 0 favours fetch, mode 1 the DMA, mode 2 the pointer
      for (int m = 0; m < 3; m++) begin
         wbXfer(1'b1, OFS_CONTROL, 32'(m));
         fork
            model.access((m == 2) ? 3 : 0, PROG_BASE, latA, errA);
            model.access(2, PROG_BASE, latB, errB);
         join
         chk32("contender latency", (m == 0) ? 32'h2 : 32'h4, 32'(latA));
         chk32("dma latency", (m == 0) ? 32'h4 : 32'h2, 32'(latB));
         chk32("contention errors", 32'h0, {30'h0, errA, errB});
         if (latA >= 20 || latB >= 20) begin
            complete_run();
         end
      end
      wbXfer(1'b1, OFS_CONTROL, CON_RESET);
      cpuDebugMode <= 1'b1;
      acc(0, UNMAPPED, 2, 1'b0);
      acc(1, UNMAPPED, 2, 1'b0);
      acc(3, UNMAPPED, 2, 1'b1);
      cpuDebugMode <= 1'b0;
      wbXfer(1'b1, OFS_ERR_MASK, 32'h0000_0004);
      wbXfer(1'b0, OFS_ERR_STATUS, 32'h0);
      chk32("status", 32'h0000_001F, rd);
      chk32("irq", 32'h1, {31'h0, irq});
      wbXfer(1'b1, OFS_ERR_STATUS, 32'h0000_0004);
      wbXfer(1'b0, OFS_ERR_STATUS, 32'h0);
      chk32("status", 32'h0000_001B, rd);
      chk32("irq", 32'h0, {31'h0, irq});
      wbXfer(1'b1, 8'h10, 32'hFFFF_FFFF);
      wbXfer(1'b0, 8'h10, 32'h0);
      chk32("unmapped offset", 32'h0, rd);
      complete_run();
   end
endmodule
`default_nettype wire
